/* tb/pio_asserts.sv */
`timescale 1ns/1ns
// ********
// event timing checks on the wires
// ********
module pio_asserts #(
	parameter int NCH = 7,
	parameter int IN_CH = 3
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [NCH-1:0] cmd1,
	input wire logic [NCH-1:0] cmd2,
	input wire logic [NCH-1:0] cmd4,
	input wire logic [NCH-1:0] sel_n,
	input wire logic [8:0][17:0] od_bus,
	input wire logic [NCH-1:0] skip_flag,
	input wire logic [11:0] slow_req_n
);
	logic [7:0] cnt_ff; // cycles since selection began
	logic slow_ff; // slow request seen in this sequence
	logic slow; // slow request seen, this cycle too
	logic od_same; // all distributor copies agree
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// count restarts in every unselected cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 8'h00;
			slow_ff <= 1'b0;
		end else if (&sel_n) begin // idle gap
			cnt_ff <= 8'h00;
			slow_ff <= 1'b0;
		end else begin // no wrap, longest run is 201 cycles
			cnt_ff <= cnt_ff + 8'h01;
			slow_ff <= slow;
		end
	end
	assign slow = slow_ff || !(&slow_req_n);
	// copies compared against channel 0
	always_comb begin
		od_same = 1'b1;
		for (int k = 1; k < 9; k++) begin
			if (od_bus[k] != od_bus[0]) begin
				od_same = 1'b0;
			end
		end
	end
	sel_onehot_a: assert property ($onehot0(~sel_n))
		else $error("two channels selected at once");
	cmd_selected_a: assert property (((cmd1 | cmd2 | cmd4) & sel_n) == '0)
		else $error("command pulse on unselected channel");
	first_event_a: assert property (|cmd1 |-> cnt_ff == 8'h00 && !(&sel_n))
		else $error("first event not at sequence start");
	second_event_a: assert property (|cmd2 |-> cnt_ff == (slow ? 8'h64 : 8'h2d))
		else $error("second event at wrong time");
	third_event_a: assert property (|cmd4 |-> cnt_ff == (slow ? 8'hc8 : 8'h3c))
		else $error("third event at wrong time");
	slow_req_a: assert property (!(&slow_req_n) |-> !(&sel_n))
		else $error("slow request without a selection");
	event_pulse_a: assert property (|cmd1 |=> !(|cmd1))
		else $error("first event pulse too long");
	od_fanout_a: assert property (od_same)
		else $error("distributor channels differ");
	flag_clear_a: assert property ($fell(skip_flag[IN_CH]) |-> $past(cmd4[IN_CH]))
		else $error("input flag fell without third event");
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
// ********
// both ends joined, user sides driven here
// ********
module tb;
	localparam logic [5:0] BASE = 6'h18; // code of channel 0
	localparam logic [5:0] RD = BASE + 6'h03; // input device code
	localparam logic [5:0] WR = BASE + 6'h04; // output device code, slow
	int seed = 32'hc0c9;
	int err_count = 0;
	int checked = 0;
	int cycles = 0; // hang guard
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic instr_valid = 1'b0;
	logic [17:0] instr = 18'h00000;
	logic acc_load = 1'b0;
	logic [17:0] acc_load_val = 18'h00000;
	logic pc_load = 1'b0;
	logic [12:0] pc_load_val = 13'h0000;
	logic link_in = 1'b0;
	logic ext_in = 1'b0;
	logic trap_in = 1'b0;
	logic [1:0] epc_in = 2'h0;
	logic usr_in_valid = 1'b0;
	logic [17:0] usr_in_data = 18'h00000;
	logic usr_out_ready = 1'b0;
	logic instr_ready, int_enabled, brk_wr_valid, busy, usr_in_ready, usr_out_valid, skip_pulse;
	logic skip_seen = 1'b0; // skip pulse seen in this sequence
	logic [4:0] spare_flag = 5'h00; // flags of channels without a device
	logic [17:0] acc, brk_wr_data, usr_out_data;
	logic [12:0] pc, brk_wr_addr;
	logic busy_d = 1'b0; // busy at previous look
	logic [12:0] exp_pc = 13'h0000; // expected program count
	logic [17:0] acc_cur = 18'h00000; // expected accumulator
	logic [17:0] w [9]; // words fed to the input device
	logic [31:0] note; // note under comparison
	logic [31:0] notes [$]; // {skip, pc, acc} after each sequence
	logic [30:0] brk_q [$]; // {address, save word} per break
	logic [17:0] out_q [$]; // words leaving the output device
	pio_if i_pio_if ();
	// channels and slots without a device are pulled idle, their skip flags taken from spare_flag
	assign i_pio_if.collect[2:0] = '0;
	assign i_pio_if.collect[6:5] = '0;
	assign i_pio_if.skip_flag[2:0] = spare_flag[2:0];
	assign i_pio_if.skip_flag[6:5] = spare_flag[4:3];
	assign i_pio_if.int_req_n[8:1] = '1;
	assign i_pio_if.slow_req_n[11:1] = '1;
	io_processor #(.CODE_BASE(BASE)) i_io_processor (.clk_sys(clk_sys), .nrst(nrst), .bus(i_pio_if.proc),
		.instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .acc_load(acc_load),
		.acc_load_val(acc_load_val), .pc_load(pc_load), .pc_load_val(pc_load_val), .link_in(link_in),
		.ext_in(ext_in), .trap_in(trap_in), .epc_in(epc_in), .acc(acc), .pc(pc), .skip_pulse(skip_pulse),
		.int_enabled(int_enabled), .brk_wr_valid(brk_wr_valid), .brk_wr_addr(brk_wr_addr),
		.brk_wr_data(brk_wr_data), .busy(busy));
	// input device, interrupting through slot 0
	io_device #(.CHAN(3), .IS_INPUT(1'b1), .INT_SLOT(0)) i_io_device (.clk_sys(clk_sys), .nrst(nrst),
		.bus(i_pio_if.periph), .usr_in_valid(usr_in_valid), .usr_in_data(usr_in_data),
		.usr_in_ready(usr_in_ready), .usr_out_valid(), .usr_out_data(), .usr_out_ready(usr_out_ready),
		.ready_flag());
	// output device on a slow channel, no interrupt
	io_device #(.CHAN(4), .IS_INPUT(1'b0), .SLOW_SLOT(0)) i_io_device_out (.clk_sys(clk_sys), .nrst(nrst),
		.bus(i_pio_if.periph), .usr_in_valid(usr_in_valid), .usr_in_data(usr_in_data), .usr_in_ready(),
		.usr_out_valid(usr_out_valid), .usr_out_data(usr_out_data), .usr_out_ready(usr_out_ready),
		.ready_flag());
	pio_asserts #(.NCH(7), .IN_CH(3)) i_pio_asserts (.clk_sys(clk_sys), .nrst(nrst), .cmd1(i_pio_if.cmd1),
		.cmd2(i_pio_if.cmd2), .cmd4(i_pio_if.cmd4), .sel_n(i_pio_if.sel_n), .od_bus(i_pio_if.od_bus),
		.skip_flag(i_pio_if.skip_flag), .slow_req_n(i_pio_if.slow_req_n));
	// free-running clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// a hang counts as a mismatch
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 10000) begin
			err_count++;
			wrap_up();
		end
	end
	// results compared with the oldest note, at settled mid-cycle
	always @(negedge clk_sys) begin
		if (skip_pulse === 1'b1) begin // skip pulse of this sequence
			skip_seen = 1'b1;
		end
		if (busy_d === 1'b1 && busy === 1'b0) begin // sequence or break ended
			note = notes.size() > 0 ? notes.pop_front() : 32'hx;
			`CHK({skip_seen, pc, acc}, note)
			skip_seen = 1'b0;
		end
		if (brk_wr_valid === 1'b1) begin // save write of a break
			note = brk_q.size() > 0 ? {1'b0, brk_q.pop_front()} : 32'hx;
			`CHK({1'b0, brk_wr_addr, brk_wr_data}, note)
		end
		if (usr_out_valid === 1'b1 && usr_out_ready === 1'b1) begin // word handed on
			note = out_q.size() > 0 ? {14'h0000, out_q.pop_front()} : 32'hx;
			`CHK({14'h0000, usr_out_data}, note)
		end
		busy_d = busy;
	end
	// one instruction, held until taken, then its sequence awaited
	task automatic issue(input logic [5:0] sel, input logic [5:0] low, input logic skip, input logic [17:0] a);
		exp_pc = exp_pc + 13'h0001 + {12'h000, skip};
		acc_cur = a;
		notes.push_back({skip, exp_pc, a});
		@(posedge clk_sys);
		#1 instr_valid = 1'b1;
		instr = {4'he, 2'b00, sel, low};
		do @(posedge clk_sys); while (instr_ready !== 1'b1);
		#1 instr_valid = 1'b0;
		while (busy === 1'b1) @(posedge clk_sys);
	endtask
	// direct load of accumulator and program count
	task automatic preload(input logic [17:0] a);
		@(posedge clk_sys);
		#1 acc_load = 1'b1;
		acc_load_val = a;
		pc_load = 1'b1;
		pc_load_val = exp_pc;
		@(posedge clk_sys);
		#1 acc_load = 1'b0;
		pc_load = 1'b0;
		acc_cur = a;
	endtask
	// one word into the input device buffer
	task automatic feed(input logic [17:0] d);
		@(posedge clk_sys);
		#1 usr_in_valid = 1'b1;
		usr_in_data = d;
		do @(posedge clk_sys); while (usr_in_ready !== 1'b1);
		#1 usr_in_valid = 1'b0;
	endtask
	task automatic wrap_up();
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		#1 nrst = 1'b1;
		spare_flag = 5'($random(seed));
		exp_pc = 13'($random(seed));
		preload(18'($random(seed)));
		// input side: no flag, then fill until refused
		issue(RD, 6'h01, 1'b0, acc_cur);
		for (int k = 0; k < 9; k++) begin
			w[k] = 18'($random(seed));
			if (k < 8) begin
				feed(w[k]);
			end
		end
		`CHK(usr_in_ready, 1'b0)
		// start the device: first word moves to its buffer, flag rises
		issue(RD, 6'h04, 1'b0, acc_cur);
		feed(w[8]);
		issue(RD, 6'h01, 1'b1, acc_cur);
		preload(18'($random(seed)));
		issue(RD, 6'h02, 1'b0, acc_cur | w[0]);
		for (int k = 0; k < 9; k++) begin
			issue(RD, 6'h0e, 1'b0, w[k]);
		end
		issue(RD, 6'h01, 1'b0, acc_cur);
		// output side: far end stalls while nine words go out
		issue(WR, 6'h01, 1'b1, acc_cur);
		for (int k = 0; k < 9; k++) begin
			preload(18'($random(seed)));
			out_q.push_back(acc_cur);
			issue(WR, 6'h06, 1'b0, acc_cur);
		end
		issue(WR, 6'h01, 1'b0, acc_cur);
		#1 usr_out_ready = 1'b1;
		while (out_q.size() > 0) @(posedge clk_sys);
		issue(WR, 6'h01, 1'b1, acc_cur);
		// interrupt system on, off, on, then a break
		issue(6'h00, 6'h22, 1'b0, acc_cur);
		`CHK(int_enabled, 1'b1)
		issue(6'h00, 6'h02, 1'b0, acc_cur);
		`CHK(int_enabled, 1'b0)
		issue(6'h00, 6'h22, 1'b0, acc_cur);
		#1 {link_in, ext_in, trap_in, epc_in} = 5'($random(seed));
		brk_q.push_back({13'h0000, link_in, ext_in, trap_in, epc_in, exp_pc});
		exp_pc = 13'h0001;
		notes.push_back({1'b0, exp_pc, acc_cur});
		feed(18'($random(seed)));
		do @(posedge clk_sys); while (busy !== 1'b1);
		while (busy === 1'b1) @(posedge clk_sys);
		`CHK(int_enabled, 1'b0)
		// flag still up but no second break while disabled
		issue(RD, 6'h01, 1'b1, acc_cur);
		`CHK(notes.size() + brk_q.size() + out_q.size(), 0)
		wrap_up();
	end
endmodule

/* verilog/io_device.sv */
`timescale 1ns/1ns
`include "pio_defines.svh"
// ****************************************
// word buffer between the device and its user side
// ****************************************
module word_fifo #(
	parameter int W = 18,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	// pointers wrap naturally only for a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("word_fifo: depth must be a power of two");

	typedef struct packed {
		logic [AW:0] wp; // write pointer with lap bit
		logic [AW:0] rp; // read pointer with lap bit
	} fifo_st_t;

	fifo_st_t st_ff;
	fifo_st_t nxt_st;
	logic [W-1:0] mem [DEPTH]; // storage, no reset needed
	logic push; // word accepted
	logic pop; // word handed on

	assign in_ready = (st_ff.wp ^ st_ff.rp) != {1'b1, {AW{1'b0}}};
	assign out_valid = st_ff.wp != st_ff.rp;
	assign out_data = mem[st_ff.rp[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer advance
	always_comb begin
		nxt_st = st_ff;
		if (push)
			nxt_st.wp = st_ff.wp + (AW+1)'(1);
		if (pop)
			nxt_st.rp = st_ff.rp + (AW+1)'(1);
	end

	// pointer registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// storage write
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[st_ff.wp[AW-1:0]] <= in_data;
	end
endmodule

// ****************************************
// one peripheral device controller on one channel
// ****************************************
module io_device #(
	parameter int CHAN = 0,
	parameter bit IS_INPUT = 1'b1,
	parameter int INT_SLOT = -1,
	parameter int SLOW_SLOT = -1,
	parameter int NCH = 7,
	parameter int NINT = 9
) (
	input wire logic clk_sys,
	input wire logic nrst,
	pio_if.periph bus,
	input wire logic usr_in_valid,
	input wire logic [17:0] usr_in_data,
	output logic usr_in_ready,
	output logic usr_out_valid,
	output logic [17:0] usr_out_data,
	input wire logic usr_out_ready,
	output logic ready_flag
);
	if (CHAN < 0 || CHAN >= NCH || INT_SLOT >= NINT || SLOW_SLOT >= `SLOW_INPUTS)
		$error("io_device: slot out of range");

	typedef struct packed {
		logic flag; // ready flag
		logic run; // operation started, waiting for the buffer
		logic [17:0] dbuf; // buffer or data register
	} dev_st_t;

	// an output device is ready after reset, an input device is not
	localparam dev_st_t RST_ST = '{flag: !IS_INPUT, run: 1'b0, dbuf: '0};

	dev_st_t st_ff;
	dev_st_t nxt_st;
	logic f_in_valid; // fifo filling side
	logic [17:0] f_in_data;
	logic f_in_ready;
	logic f_out_valid; // fifo draining side
	logic [17:0] f_out_data;
	logic f_out_ready;

	// ****************************************
	// buffer: user words in for input, out for output
	// ****************************************
	word_fifo #(.W(18), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(f_in_valid),
		.in_data(f_in_data),
		.in_ready(f_in_ready),
		.out_valid(f_out_valid),
		.out_data(f_out_data),
		.out_ready(f_out_ready)
	);

	// routing of the fifo by direction
	always_comb begin
		if (IS_INPUT) begin
			f_in_valid = usr_in_valid;
			f_in_data = usr_in_data;
			usr_in_ready = f_in_ready;
			usr_out_valid = 1'b0;
			usr_out_data = '0;
			// only draw a word once started and emptied
			f_out_ready = st_ff.run && !st_ff.flag;
		end else begin
			// a full fifo holds the run bit, stalling the device
			f_in_valid = st_ff.run;
			f_in_data = st_ff.dbuf;
			usr_in_ready = 1'b0;
			usr_out_valid = f_out_valid;
			usr_out_data = f_out_data;
			f_out_ready = usr_out_ready;
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		if (IS_INPUT) begin
			if (bus.cmd4[CHAN]) begin
				nxt_st.flag = 1'b0;
				nxt_st.run = 1'b1;
			end
			// set after clear so a coincident load is kept
			if (f_out_valid && f_out_ready) begin
				nxt_st.dbuf = f_out_data;
				nxt_st.flag = 1'b1;
				nxt_st.run = 1'b0;
			end
		end else begin
			if (bus.cmd2[CHAN])
				nxt_st.dbuf = bus.od_bus[CHAN+1];
			if (f_in_valid && f_in_ready) begin
				nxt_st.run = 1'b0;
				nxt_st.flag = 1'b1;
			end
			if (bus.cmd4[CHAN]) begin
				nxt_st.run = 1'b1;
				nxt_st.flag = 1'b0;
			end
		end
	end

	// registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= RST_ST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// drive own slots on the shared wires
	// ****************************************
	// an output device offers nothing, else its old word would be ORed in
	assign bus.collect[CHAN] = IS_INPUT ? st_ff.dbuf : 18'h00000;
	assign bus.skip_flag[CHAN] = st_ff.flag;
	assign ready_flag = st_ff.flag;
	if (INT_SLOT >= 0) begin : g_int
		assign bus.int_req_n[INT_SLOT] = ~st_ff.flag;
	end
	if (SLOW_SLOT >= 0) begin : g_slow
		assign bus.slow_req_n[SLOW_SLOT] = bus.sel_n[CHAN];
	end
endmodule

/* verilog/io_processor.sv */
`timescale 1ns/1ns
`include "pio_defines.svh"
module io_processor import pio_pkg::*; #(
	parameter int NCH = 7,
	parameter int NINT = 9,
	parameter int SLOW_DELAY_NS = 1000,
	parameter logic [5:0] CODE_BASE = 6'h18
) (
	input wire logic clk_sys,
	input wire logic nrst,
	pio_if.proc bus,
	input wire logic instr_valid,
	input wire logic [17:0] instr,
	output logic instr_ready,
	input wire logic acc_load,
	input wire logic [17:0] acc_load_val,
	input wire logic pc_load,
	input wire logic [12:0] pc_load_val,
	input wire logic link_in,
	input wire logic ext_in,
	input wire logic trap_in,
	input wire logic [1:0] epc_in,
	output logic [17:0] acc,
	output logic [12:0] pc,
	output logic skip_pulse,
	output logic int_enabled,
	output logic brk_wr_valid,
	output logic [12:0] brk_wr_addr,
	output logic [17:0] brk_wr_data,
	output logic busy
);
	// ****************************************
	// timing
	// ****************************************
	localparam int GAP57 = `NS_TO_CYC(`T5_T7_NS); // cycles T5 to T7
	localparam int GAP71 = `NS_TO_CYC(`T7_T1_NS); // cycles T7 to T1
	localparam int GAPSL = `NS_TO_CYC(SLOW_DELAY_NS); // slow cycle gap
	localparam logic [`CNT_W-1:0] LD57 = `CNT_W'(GAP57 - 2);
	localparam logic [`CNT_W-1:0] LD71 = `CNT_W'(GAP71 - 2);
	localparam logic [`CNT_W-1:0] LDSL = `CNT_W'(GAPSL - 2);

	// refuse shapes the collector and counters cannot serve
	if (NCH % 7 != 0 || NCH > 14 || NINT % `NOR_GRP != 0 || GAPSL < 2 || GAPSL >= (1 << `CNT_W))
		$error("io_processor: unsupported parameter values");

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		pstate_t st; // event sequencer
		logic [`CNT_W-1:0] cnt; // gap between event pulses
		logic slow; // slow cycle taken for this instruction
		logic [17:0] acc; // accumulator
		logic [12:0] pc; // program count
		logic [17:0] ir; // transfer instruction held
		logic ie; // interrupt system enabled
		logic skip; // one-cycle skip pulse
		logic wr; // one-cycle save write strobe
		logic [17:0] wrd; // saved word
	} proc_st_t;

	proc_st_t st_ff;
	proc_st_t nxt_st;

	// ****************************************
	// helpers
	// ****************************************
	// ground-level nor: true when any input sits low
	function automatic logic any_low(input logic [15:0] v, input int n);
		logic r;
		r = 1'b0;
		for (int i = 0; i < n; i++)
			r = r | ~v[i];
		return r;
	endfunction

	// select code of one channel
	function automatic logic [5:0] chan_code(input int i);
		return CODE_BASE + 6'(i);
	endfunction

	logic active; // an instruction is in its event sequence
	logic [5:0] sel; // device select code
	logic ev1; // first_event_pulse this cycle
	logic ev2; // second_event_pulse this cycle
	logic ev4; // third_event_pulse this cycle
	logic slow_any; // slow cycle request gate
	logic [NINT/`NOR_GRP-1:0] grp; // outputs of the 3-input gates
	logic int_any; // any interrupt request
	logic [17:0] coll_word; // collector output
	logic [17:0] status_word; // status bits on their collector channel
	save_word_t sv; // save word assembly

	// ****************************************
	// decode and device selection
	// ****************************************
	assign active = st_ff.st != S_IDLE && st_ff.st != S_BRK;
	assign sel = st_ff.ir[`SEL_HI:`SEL_LO];
	assign ev1 = st_ff.st == S_T5 && st_ff.ir[`EV1_BIT];
	assign ev2 = st_ff.st == S_T7 && st_ff.ir[`EV2_BIT];
	assign ev4 = st_ff.st == S_T1 && st_ff.ir[`EV4_BIT];

	// per-channel command pulses, gated by the select match
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			bus.sel_n[i] = ~(active && sel == chan_code(i));
			bus.cmd1[i] = ev1 && !bus.sel_n[i];
			bus.cmd2[i] = ev2 && !bus.sel_n[i];
			bus.cmd4[i] = ev4 && !bus.sel_n[i];
		end
	end

	// slow cycle gate over twelve ground-active inputs
	assign slow_any = any_low(16'(bus.slow_req_n), `SLOW_INPUTS);

	// interrupt requests combined three at a time
	always_comb begin
		for (int g = 0; g < NINT / `NOR_GRP; g++)
			grp[g] = any_low(16'(bus.int_req_n[g*`NOR_GRP +: `NOR_GRP]), `NOR_GRP);
	end
	assign int_any = |grp;

	// ****************************************
	// collector: gated channels ORed together
	// ****************************************
	always_comb begin
		status_word = '0;
		status_word[NCH-1:0] = bus.skip_flag;
		status_word[17] = st_ff.ie;
		status_word[16] = int_any;
		coll_word = '0;
		for (int i = 0; i < NCH; i++) begin
			if (bus.cmd2[i]) begin
				// status channel is filled here, not by a device
				if (i % 7 == `STAT_CH)
					coll_word = coll_word | status_word;
				else if (i % 7 == `TTY_CH)
					coll_word = coll_word | {10'h000, bus.collect[i][`TTY_BITS-1:0]};
				else
					coll_word = coll_word | bus.collect[i];
			end
		end
	end

	// ****************************************
	// distributor: one copy of the accumulator register per channel
	// ****************************************
	always_comb begin
		for (int c = 0; c < `OD_CH; c++)
			bus.od_bus[c] = st_ff.acc;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.skip = 1'b0;
		nxt_st.wr = 1'b0;
		sv.link = link_in;
		sv.ext = ext_in;
		sv.trap = trap_in;
		sv.extended_program_count = epc_in;
		sv.pc = st_ff.pc;
		if (acc_load)
			nxt_st.acc = acc_load_val;
		if (pc_load)
			nxt_st.pc = pc_load_val;
		case (st_ff.st)
			S_IDLE: begin
				// a pending break wins over a new instruction
				if (st_ff.ie && int_any) begin
					nxt_st.st = S_BRK;
					nxt_st.wrd = sv;
					nxt_st.wr = 1'b1;
					nxt_st.pc = `RESUME_ADDR;
					nxt_st.ie = 1'b0;
				end else if (instr_valid) begin
					nxt_st.ir = instr;
					nxt_st.pc = st_ff.pc + 13'h0001;
					// other opcodes are not this block's business
					if (instr[`OP_HI:`OP_LO] == `OP_IOT)
						nxt_st.st = S_T5;
				end
			end
			S_T5: begin
				nxt_st.slow = slow_any;
				nxt_st.cnt = slow_any ? LDSL : LD57;
				nxt_st.st = S_W57;
				if (st_ff.ir[`CLR_ACC_BIT])
					nxt_st.acc = '0;
				if (|(bus.skip_flag & bus.cmd1)) begin
					nxt_st.pc = nxt_st.pc + 13'h0001;
					nxt_st.skip = 1'b1;
				end
			end
			S_W57: begin
				nxt_st.cnt = st_ff.cnt - `CNT_W'(1);
				if (st_ff.cnt == '0)
					nxt_st.st = S_T7;
			end
			S_T7: begin
				nxt_st.acc = nxt_st.acc | coll_word;
				if (ev2 && sel == `CTL_CODE)
					nxt_st.ie = st_ff.ir[`ION_BIT];
				nxt_st.cnt = st_ff.slow ? LDSL : LD71;
				nxt_st.st = S_W71;
			end
			S_W71: begin
				nxt_st.cnt = st_ff.cnt - `CNT_W'(1);
				if (st_ff.cnt == '0)
					nxt_st.st = S_T1;
			end
			S_T1: begin
				nxt_st.st = S_IDLE;
			end
			S_BRK: begin
				// one cycle of break; the enable cleared on entry keeps a second break out
				nxt_st.st = S_IDLE;
			end
			default: begin
				nxt_st.st = S_IDLE;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// user-side outputs
	// ****************************************
	assign instr_ready = st_ff.st == S_IDLE && !(st_ff.ie && int_any);
	assign acc = st_ff.acc;
	assign pc = st_ff.pc;
	assign skip_pulse = st_ff.skip;
	assign int_enabled = st_ff.ie;
	assign brk_wr_valid = st_ff.wr;
	assign brk_wr_addr = `SAVE_ADDR;
	assign brk_wr_data = st_ff.wrd;
	assign busy = st_ff.st != S_IDLE;
endmodule

/* verilog/pio_defines.svh */
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH
// ****************************************
// clock and event timing
// ****************************************
`define CLK_MHZ 100
`define T5_T7_NS 450
`define T7_T1_NS 150
// least gaps round up to whole cycles
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)
// ****************************************
// instruction word fields, bit 17 is the msb
// ****************************************
`define WORD_W 18
`define OP_HI 17
`define OP_LO 14
`define OP_IOT 4'he
`define SEL_HI 11
`define SEL_LO 6
`define SEL_W 6
`define CLR_ACC_BIT 3
`define ION_BIT 5
`define EV1_BIT 0
`define EV2_BIT 1
`define EV4_BIT 2
`define CTL_CODE 6'h00
// ****************************************
// collector and distributor layout
// ****************************************
`define TAPE_CH 0
`define STAT_CH 1
`define TTY_CH 2
`define TTY_BITS 8
`define OD_CH 9
`define SLOW_INPUTS 12
`define NOR_GRP 3
// ****************************************
// break save area
// ****************************************
`define PC_W 13
`define EPC_W 2
`define SAVE_ADDR 13'h0000
`define RESUME_ADDR 13'h0001
`define CNT_W 10
`define FIFO_DEPTH 8
`endif

/* verilog/pio_if.sv */
`timescale 1ns/1ns
// ****************************************
// wires between the processor and its device controllers
// ****************************************
interface pio_if #(parameter int NCH = 7, parameter int NINT = 9);
	logic [NCH-1:0] cmd1; // first_event_pulse per channel
	logic [NCH-1:0] cmd2; // second_event_pulse per channel
	logic [NCH-1:0] cmd4; // third_event_pulse per channel
	logic [NCH-1:0] sel_n; // ground-active channel select level
	logic [8:0][17:0] od_bus; // output_distribution_bus channels
	logic [NCH-1:0][17:0] collect; // input_collector_mux channel words
	logic [NCH-1:0] skip_flag; // flags wired to flag_skip_facility
	logic [NINT-1:0] int_req_n; // active-low interrupt requests
	logic [11:0] slow_req_n; // ground-active slow cycle requests
	modport proc (output cmd1, output cmd2, output cmd4, output sel_n, output od_bus,
		input collect, input skip_flag, input int_req_n, input slow_req_n);
	modport periph (input cmd1, input cmd2, input cmd4, input sel_n, input od_bus,
		output collect, output skip_flag, output int_req_n, output slow_req_n);
endinterface

/* verilog/pio_pkg.sv */
package pio_pkg;
	// event sequencer of one transfer instruction
	typedef enum logic [2:0] {S_IDLE, S_T5, S_W57, S_T7, S_W71, S_T1, S_BRK} pstate_t;
	// word stored at the save location on a break
	typedef struct packed {
		logic link;
		logic ext;
		logic trap;
		logic [1:0] extended_program_count;
		logic [12:0] pc;
	} save_word_t;
endpackage
